// ### verilog/snp_packetizer.sv
`timescale 1ns/100ps
module snp_packetizer import snp_pkg::*; #(
    parameter int CHANNEL = 0,
    parameter int MS_CYCLES = SNP_MS_CYCLES,
    parameter int MS_PER_S = SNP_MS_PER_S
) (
    // Clock and reset.
    input wire logic CLK,
    input wire logic RST,
    // APB register port.
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Serial byte stream from the UART receiver.
    input wire logic SER_VALID,
    input wire logic [7:0] SER_DATA,
    // Connection events from the network stack.
    input wire logic NET_REQ,
    input wire logic NET_UP,
    input wire logic NET_RX_VALID,
    input wire logic [7:0] NET_RX_DATA,
    // Connection control towards the network stack.
    output logic NET_LISTEN,
    output logic NET_DIAL,
    output logic NET_UDP,
    output logic NET_ACCEPT,
    output logic NET_REFUSE,
    output logic NET_CLOSE,
    output logic NET_AUTH,
    output logic [15:0] NET_LPORT,
    output logic [15:0] NET_RPORT,
    output logic [31:0] NET_RIP,
    // Outgoing payload and packet boundary.
    output logic NET_TX_VALID,
    output logic [7:0] NET_TX_DATA,
    output logic NET_PUSH,
    // Serial configuration entry enable.
    output logic CFG_ENTRY
);

    localparam int PW = $clog2(MS_CYCLES);
    localparam int SW = $clog2(MS_PER_S);

    typedef struct packed {
        snp_state_t st;
        logic client_role;
        logic linked;
        logic [1:0] mode;
        logic pw_en;
        logic cfg_en;
        logic [15:0] inact;
        logic [15:0] ptime;
        logic [7:0] psize;
        logic [7:0] pchar;
        logic [31:0] ports;
        logic [31:0] rip;
        logic [31:0] pw;
        logic [PW-1:0] presc;
        logic [SW-1:0] ms_in_s;
        logic [15:0] pack_ms;
        logic [15:0] idle_s;
        logic [7:0] cnt;
        logic [1:0] pw_idx;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic accept;
        logic refuse;
        logic close;
        logic tx_valid;
        logic [7:0] tx_data;
        logic push;
    } snp_regs_t;

    snp_regs_t r_ff;
    snp_regs_t nxt_r;
    logic ms_tick;
    logic s_tick;
    logic close_cmd;
    logic timeout;
    logic activity;
    logic all_off;
    logic is_delim;
    logic [31:0] rd;

    function automatic logic snp_mapped(input logic [7:0] a);
        snp_mapped = (a == SNP_OFS_CTRL) || (a == SNP_OFS_INACT) || (a == SNP_OFS_PTIME) ||
                     (a == SNP_OFS_PSIZE) || (a == SNP_OFS_PCHAR) || (a == SNP_OFS_PORTS) ||
                     (a == SNP_OFS_PEERIP) || (a == SNP_OFS_PASSWD) || (a == SNP_OFS_STATUS);
    endfunction : snp_mapped

    function automatic snp_state_t snp_wait_state(input logic [1:0] m);
        snp_wait_state = (m == SNP_MODE_CLIENT) ? SNP_DIAL : SNP_LISTEN;
    endfunction : snp_wait_state

    always_comb begin
        unique case (PADDR)
            SNP_OFS_CTRL: rd = {27'h000_0000, 1'b0, r_ff.cfg_en, r_ff.pw_en, r_ff.mode};
            SNP_OFS_INACT: rd = {16'h0000, r_ff.inact};
            SNP_OFS_PTIME: rd = {16'h0000, r_ff.ptime};
            SNP_OFS_PSIZE: rd = {24'h00_0000, r_ff.psize};
            SNP_OFS_PCHAR: rd = {24'h00_0000, r_ff.pchar};
            SNP_OFS_PORTS: rd = r_ff.ports;
            SNP_OFS_PEERIP: rd = r_ff.rip;
            SNP_OFS_PASSWD: rd = r_ff.pw;
            SNP_OFS_STATUS: rd = {16'h0000, r_ff.cnt, 3'h0, NET_AUTH, r_ff.client_role, r_ff.st};
            default: rd = 32'h0000_0000;
        endcase
    end

    always_comb begin
        nxt_r = r_ff;
        nxt_r.accept = 1'b0;
        nxt_r.refuse = 1'b0;
        nxt_r.close = 1'b0;
        nxt_r.tx_valid = 1'b0;
        nxt_r.push = 1'b0;
        nxt_r.pslverr = 1'b0;
        close_cmd = 1'b0;

        // One wait state: pready is high in the second access cycle, writes land on the edge that ends it.
        if (PSEL && PENABLE && !r_ff.pready) begin
            nxt_r.pready = 1'b1;
            nxt_r.pslverr = !snp_mapped(PADDR);
            nxt_r.prdata = rd;
        end else begin
            nxt_r.pready = 1'b0;
        end
        if (PSEL && PENABLE && r_ff.pready && PWRITE) begin
            unique case (PADDR)
                SNP_OFS_CTRL: begin
                    nxt_r.mode = PWDATA[SNP_CTRL_MODE_LSB +: 2];
                    nxt_r.pw_en = PWDATA[SNP_CTRL_PWEN_BIT];
                    nxt_r.cfg_en = PWDATA[SNP_CTRL_CFGEN_BIT] && (CHANNEL == 0);
                    close_cmd = PWDATA[SNP_CTRL_CLOSE_BIT];
                    if (PWDATA[SNP_CTRL_MODE_LSB +: 2] != r_ff.mode) begin
                        nxt_r.st = SNP_IDLE;
                    end
                end
                SNP_OFS_INACT: nxt_r.inact = PWDATA[15:0];
                SNP_OFS_PTIME: nxt_r.ptime = PWDATA[15:0];
                SNP_OFS_PSIZE: nxt_r.psize = PWDATA[7:0];
                SNP_OFS_PCHAR: nxt_r.pchar = PWDATA[7:0];
                SNP_OFS_PORTS: nxt_r.ports = PWDATA;
                SNP_OFS_PEERIP: nxt_r.rip = PWDATA;
                SNP_OFS_PASSWD: nxt_r.pw = PWDATA;
                default: nxt_r.pready = 1'b0;
            endcase
        end

        // Millisecond and second ticks; a serial byte restarts the millisecond phase.
        ms_tick = (r_ff.presc == PW'(MS_CYCLES - 1));
        s_tick = ms_tick && (r_ff.ms_in_s == SW'(MS_PER_S - 1));
        nxt_r.presc = (ms_tick || SER_VALID) ? '0 : r_ff.presc + PW'(1);
        if (ms_tick) begin
            nxt_r.ms_in_s = s_tick ? '0 : r_ff.ms_in_s + SW'(1);
        end

        // Packing: each enabled condition can close a packet on its own.
        all_off = (r_ff.ptime == 16'h0000) && (r_ff.psize == 8'h00) && (r_ff.pchar == 8'h00);
        is_delim = (r_ff.pchar != 8'h00) && (SER_DATA == r_ff.pchar);
        if (SER_VALID) begin
            nxt_r.pack_ms = 16'h0000;
            if (is_delim) begin
                nxt_r.push = (r_ff.cnt != 8'h00);
                nxt_r.cnt = 8'h00;
            end else begin
                nxt_r.tx_valid = 1'b1;
                nxt_r.tx_data = SER_DATA;
                if (all_off) begin
                    nxt_r.push = 1'b1;
                    nxt_r.cnt = 8'h00;
                end else if ((r_ff.psize != 8'h00) && (r_ff.cnt + 8'h01 >= r_ff.psize)) begin
                    nxt_r.push = 1'b1;
                    nxt_r.cnt = 8'h00;
                end else if (r_ff.cnt != 8'hFF) begin
                    nxt_r.cnt = r_ff.cnt + 8'h01;
                end
            end
        end else if (ms_tick && (r_ff.ptime != 16'h0000) && (r_ff.cnt != 8'h00)) begin
            if (r_ff.pack_ms >= r_ff.ptime - 16'h0001) begin
                nxt_r.push = 1'b1;
                nxt_r.cnt = 8'h00;
                nxt_r.pack_ms = 16'h0000;
            end else begin
                nxt_r.pack_ms = r_ff.pack_ms + 16'h0001;
            end
        end

        // Inactivity seconds, restarted by traffic in either direction.
        activity = SER_VALID || NET_RX_VALID;
        if (activity) begin
            nxt_r.idle_s = 16'h0000;
        end else if (s_tick && (r_ff.idle_s != 16'hFFFF)) begin
            nxt_r.idle_s = r_ff.idle_s + 16'h0001;
        end
        timeout = (r_ff.inact != 16'h0000) && (r_ff.idle_s >= r_ff.inact);

        // A peer knocking while the device is not listening is turned away.
        if (NET_REQ && (r_ff.st != SNP_LISTEN)) begin
            nxt_r.refuse = 1'b1;
        end

        unique case (r_ff.st)
            SNP_IDLE: begin
                nxt_r.st = (r_ff.mode == SNP_MODE_UDP) ? SNP_UDP : snp_wait_state(r_ff.mode);
                nxt_r.client_role = (r_ff.mode == SNP_MODE_CLIENT);
            end
            SNP_LISTEN: begin
                if (NET_REQ) begin
                    nxt_r.accept = 1'b1;
                    nxt_r.pw_idx = 2'h0;
                    nxt_r.linked = 1'b0;
                    nxt_r.idle_s = 16'h0000;
                    nxt_r.st = (r_ff.pw_en && (r_ff.mode == SNP_MODE_SERVER)) ? SNP_AUTH : SNP_OPEN;
                end else if ((r_ff.mode == SNP_MODE_MIXED) && SER_VALID) begin
                    nxt_r.st = SNP_DIAL;
                    nxt_r.client_role = 1'b1;
                end
            end
            SNP_DIAL: begin
                if (close_cmd && (r_ff.mode == SNP_MODE_MIXED)) begin
                    nxt_r.st = SNP_LISTEN;
                    nxt_r.client_role = 1'b0;
                end else if (NET_UP) begin
                    nxt_r.st = SNP_OPEN;
                    nxt_r.linked = 1'b1;
                    nxt_r.idle_s = 16'h0000;
                end
            end
            SNP_AUTH, SNP_OPEN: begin
                // The stack raises the link some cycles after an accept, so only a link seen up can drop.
                nxt_r.linked = r_ff.linked || NET_UP;
                if ((r_ff.linked && !NET_UP) || timeout || close_cmd) begin
                    nxt_r.close = NET_UP;
                    nxt_r.st = snp_wait_state(r_ff.mode);
                    nxt_r.client_role = (r_ff.mode == SNP_MODE_CLIENT);
                end else if ((r_ff.st == SNP_AUTH) && NET_RX_VALID) begin
                    if (NET_RX_DATA == r_ff.pw[8 * r_ff.pw_idx +: 8]) begin
                        if (r_ff.pw_idx == 2'(SNP_PW_BYTES - 1)) begin
                            nxt_r.st = SNP_OPEN;
                        end else begin
                            nxt_r.pw_idx = r_ff.pw_idx + 2'h1;
                        end
                    end else begin
                        nxt_r.pw_idx = (NET_RX_DATA == r_ff.pw[7:0]) ? 2'h1 : 2'h0;
                    end
                end
            end
            SNP_UDP: begin
                if (r_ff.mode != SNP_MODE_UDP) begin
                    nxt_r.st = SNP_IDLE;
                end
            end
            default: nxt_r.st = SNP_IDLE;
        endcase
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            r_ff <= '0;
            r_ff.mode <= SNP_RST_MODE;
            r_ff.inact <= SNP_RST_INACT;
            r_ff.ptime <= SNP_RST_PTIME;
            r_ff.psize <= SNP_RST_PSIZE;
            r_ff.pchar <= SNP_RST_PCHAR;
            r_ff.ports <= SNP_RST_PORTS;
            r_ff.rip <= SNP_RST_PEERIP;
            r_ff.pw <= SNP_RST_PASSWD;
        end else begin
            r_ff <= nxt_r;
        end
    end

    // State flags are registered with the state itself, so they are flip-flop outputs.
    logic listen_ff;
    logic dial_ff;
    logic udp_ff;
    logic auth_ff;

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            listen_ff <= 1'b0;
            dial_ff <= 1'b0;
            udp_ff <= 1'b0;
            auth_ff <= 1'b0;
        end else begin
            listen_ff <= (nxt_r.st == SNP_LISTEN);
            dial_ff <= (nxt_r.st == SNP_DIAL);
            udp_ff <= (nxt_r.st == SNP_UDP);
            auth_ff <= (nxt_r.st == SNP_OPEN) || (nxt_r.st == SNP_UDP);
        end
    end

    assign PRDATA = r_ff.prdata;
    assign PREADY = r_ff.pready;
    assign PSLVERR = r_ff.pslverr;
    assign NET_LISTEN = listen_ff;
    assign NET_DIAL = dial_ff;
    assign NET_UDP = udp_ff;
    assign NET_AUTH = auth_ff;
    assign NET_ACCEPT = r_ff.accept;
    assign NET_REFUSE = r_ff.refuse;
    assign NET_CLOSE = r_ff.close;
    assign NET_LPORT = r_ff.ports[15:0];
    assign NET_RPORT = r_ff.ports[31:16];
    assign NET_RIP = r_ff.rip;
    assign NET_TX_VALID = r_ff.tx_valid;
    assign NET_TX_DATA = r_ff.tx_data;
    assign NET_PUSH = r_ff.push;
    assign CFG_ENTRY = r_ff.cfg_en;

    sequence s_idle_expired;
        (r_ff.st == SNP_OPEN) && NET_UP && (r_ff.inact != 16'h0000) && (r_ff.idle_s >= r_ff.inact);
    endsequence

    sequence s_timer_due;
        ms_tick && !SER_VALID && (r_ff.ptime != 16'h0000) && (r_ff.cnt != 8'h00) &&
            (r_ff.pack_ms >= r_ff.ptime - 16'h0001);
    endsequence

    property p_idle_close;
        @(posedge CLK) disable iff (RST) s_idle_expired |=> NET_CLOSE && !NET_AUTH;
    endproperty
    a_idle_close: assert property (p_idle_close) else $error("idle connection not closed");

    property p_no_timeout;
        @(posedge CLK) disable iff (RST)
            (r_ff.st == SNP_OPEN) && NET_UP && !close_cmd && (r_ff.inact == 16'h0000) &&
            !(PSEL && PENABLE && r_ff.pready && PWRITE && (PADDR == SNP_OFS_CTRL)) |=> r_ff.st == SNP_OPEN;
    endproperty
    a_no_timeout: assert property (p_no_timeout) else $error("zero interval closed link");

    property p_wait_after_close;
        @(posedge CLK) disable iff (RST) NET_CLOSE |-> (r_ff.st == SNP_LISTEN) || (r_ff.st == SNP_DIAL);
    endproperty
    a_wait_after_close: assert property (p_wait_after_close) else $error("not waiting after close");

    property p_refuse;
        @(posedge CLK) disable iff (RST) NET_REQ && (r_ff.st != SNP_LISTEN) |=> NET_REFUSE && !NET_ACCEPT;
    endproperty
    a_refuse: assert property (p_refuse) else $error("second peer not refused");

    property p_immediate;
        @(posedge CLK) disable iff (RST)
            SER_VALID && (r_ff.ptime == 16'h0000) && (r_ff.psize == 8'h00) && (r_ff.pchar == 8'h00)
            |=> NET_TX_VALID && NET_PUSH && (NET_TX_DATA == $past(SER_DATA));
    endproperty
    a_immediate: assert property (p_immediate) else $error("byte not forwarded at once");

    property p_timer_push;
        @(posedge CLK) disable iff (RST) s_timer_due |=> NET_PUSH ##1 !NET_PUSH;
    endproperty
    a_timer_push: assert property (p_timer_push) else $error("packing time push missing");

    property p_no_empty_push;
        @(posedge CLK) disable iff (RST) NET_PUSH && !$past(SER_VALID) |-> $past(r_ff.cnt) != 8'h00;
    endproperty
    a_no_empty_push: assert property (p_no_empty_push) else $error("empty timed packet");

    property p_size_push;
        @(posedge CLK) disable iff (RST)
            SER_VALID && !is_delim && (r_ff.psize != 8'h00) && (r_ff.cnt + 8'h01 == r_ff.psize)
            |=> NET_PUSH && (r_ff.cnt == 8'h00);
    endproperty
    a_size_push: assert property (p_size_push) else $error("size limit push missing");

    property p_delim;
        @(posedge CLK) disable iff (RST) SER_VALID && is_delim |=> !NET_TX_VALID && (r_ff.cnt == 8'h00);
    endproperty
    a_delim: assert property (p_delim) else $error("delimiter forwarded");

    property p_mixed_dial;
        @(posedge CLK) disable iff (RST)
            (r_ff.st == SNP_LISTEN) && (r_ff.mode == SNP_MODE_MIXED) && SER_VALID && !NET_REQ
            |=> NET_DIAL && r_ff.client_role;
    endproperty
    a_mixed_dial: assert property (p_mixed_dial) else $error("mixed mode did not dial");

    property p_pw_hold;
        @(posedge CLK) disable iff (RST)
            (r_ff.st == SNP_LISTEN) && NET_REQ && r_ff.pw_en && (r_ff.mode == SNP_MODE_SERVER)
            |=> NET_ACCEPT && !NET_AUTH && (r_ff.st == SNP_AUTH);
    endproperty
    a_pw_hold: assert property (p_pw_hold) else $error("access granted before password");

    property p_cfg_chan;
        @(posedge CLK) disable iff (RST) PSEL && PENABLE && PREADY && PWRITE && (PADDR == SNP_OFS_CTRL) &&
            PWDATA[SNP_CTRL_CFGEN_BIT] |=> CFG_ENTRY == (CHANNEL == 0);
    endproperty
    a_cfg_chan: assert property (p_cfg_chan) else $error("config entry on second channel");

endmodule : snp_packetizer

// ### verilog/snp_pkg.sv
package snp_pkg;

    typedef enum logic [2:0] {SNP_IDLE, SNP_LISTEN, SNP_DIAL, SNP_AUTH, SNP_OPEN, SNP_UDP} snp_state_t;

    localparam logic [1:0] SNP_MODE_CLIENT = 2'h0;
    localparam logic [1:0] SNP_MODE_SERVER = 2'h1;
    localparam logic [1:0] SNP_MODE_MIXED = 2'h2;
    localparam logic [1:0] SNP_MODE_UDP = 2'h3;

    localparam logic [7:0] SNP_OFS_CTRL = 8'h00;
    localparam logic [7:0] SNP_OFS_INACT = 8'h04;
    localparam logic [7:0] SNP_OFS_PTIME = 8'h08;
    localparam logic [7:0] SNP_OFS_PSIZE = 8'h0C;
    localparam logic [7:0] SNP_OFS_PCHAR = 8'h10;
    localparam logic [7:0] SNP_OFS_PORTS = 8'h14;
    localparam logic [7:0] SNP_OFS_PEERIP = 8'h18;
    localparam logic [7:0] SNP_OFS_PASSWD = 8'h1C;
    localparam logic [7:0] SNP_OFS_STATUS = 8'h20;

    localparam int SNP_CTRL_MODE_LSB = 0;
    localparam int SNP_CTRL_PWEN_BIT = 2;
    localparam int SNP_CTRL_CFGEN_BIT = 3;
    localparam int SNP_CTRL_CLOSE_BIT = 4;

    localparam logic [1:0] SNP_RST_MODE = SNP_MODE_SERVER;
    localparam logic [15:0] SNP_RST_INACT = 16'h0000;
    localparam logic [15:0] SNP_RST_PTIME = 16'h0000;
    localparam logic [7:0] SNP_RST_PSIZE = 8'h00;
    localparam logic [7:0] SNP_RST_PCHAR = 8'h00;
    localparam logic [31:0] SNP_RST_PORTS = 32'h0000_0000;
    localparam logic [31:0] SNP_RST_PEERIP = 32'h0000_0000;
    localparam logic [31:0] SNP_RST_PASSWD = 32'h0000_0000;

    localparam int SNP_PW_BYTES = 4;
    localparam int SNP_CLK_HZ = 50_000_000;
    localparam int SNP_TICK_MS = 1;
    localparam int SNP_MS_CYCLES = SNP_CLK_HZ / 1000 * SNP_TICK_MS;
    localparam int SNP_MS_PER_S = 1000;

endpackage : snp_pkg

// ### testbench/snp_net_model.sv
`timescale 1ns/100ps
module snp_net_model (
    // Clock and reset.
    input wire logic CLK,
    input wire logic RST,
    // Connection control from the block.
    input wire logic NET_LISTEN,
    input wire logic NET_DIAL,
    input wire logic NET_ACCEPT,
    input wire logic NET_CLOSE,
    // Payload from the block.
    input wire logic NET_TX_VALID,
    input wire logic [7:0] NET_TX_DATA,
    input wire logic NET_PUSH,
    // Link state and tallies.
    output logic NET_UP,
    output logic [15:0] N_BYTES,
    output logic [15:0] N_PUSH,
    output logic [15:0] N_CLOSE,
    output logic [7:0] LAST_BYTE
);
    logic [2:0] dial_cnt;
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            NET_UP <= 1'b0;
            dial_cnt <= 3'h0;
            N_BYTES <= 16'h0000;
            N_PUSH <= 16'h0000;
            N_CLOSE <= 16'h0000;
            LAST_BYTE <= 8'h00;
        end else begin
            // A listening device holds no link, so any old one is gone.
            if (NET_CLOSE || NET_LISTEN) begin
                NET_UP <= 1'b0;
                dial_cnt <= 3'h0;
            end else if (NET_ACCEPT) begin
                NET_UP <= 1'b1;
            end else if (NET_DIAL && !NET_UP) begin
                dial_cnt <= dial_cnt + 3'h1;
                NET_UP <= (dial_cnt == 3'h4);
            end
            if (NET_CLOSE) begin
                N_CLOSE <= N_CLOSE + 16'h0001;
            end
            if (NET_TX_VALID) begin
                N_BYTES <= N_BYTES + 16'h0001;
                LAST_BYTE <= NET_TX_DATA;
            end
            if (NET_PUSH) begin
                N_PUSH <= N_PUSH + 16'h0001;
            end
        end
    end
endmodule : snp_net_model

// ### testbench/tb.sv
`timescale 1ns/100ps
module tb;
    import snp_pkg::*;
    logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, ser_valid = 0, net_req = 0, rx_valid = 0;
    logic [7:0] paddr = 8'h00, ser_data = 8'h00, rx_data = 8'h00, last_byte;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd, peer_ip;
    logic pready, pslverr, listen, dial, udp, accept, refuse, close, auth, tx_valid, push, cfg, net_up, err;
    logic [7:0] tx_data;
    logic [15:0] lport, rport, n_bytes, n_push, n_close, b0, p0, c0;
    wire [4:0] ev = {auth, dial, refuse, accept, close};
    int n_errors = 0, num_checks = 0, cycles = 0;
    always #10 clk = ~clk;
    snp_packetizer #(.CHANNEL(0), .MS_CYCLES(50), .MS_PER_S(10)) u_snp_packetizer (.CLK(clk), .RST(rst),
        .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .SER_VALID(ser_valid), .SER_DATA(ser_data), .NET_REQ(net_req),
        .NET_UP(net_up), .NET_RX_VALID(rx_valid), .NET_RX_DATA(rx_data), .NET_LISTEN(listen), .NET_DIAL(dial),
        .NET_UDP(udp), .NET_ACCEPT(accept), .NET_REFUSE(refuse), .NET_CLOSE(close), .NET_AUTH(auth),
        .NET_LPORT(lport), .NET_RPORT(rport), .NET_RIP(peer_ip), .NET_TX_VALID(tx_valid), .NET_TX_DATA(tx_data),
        .NET_PUSH(push), .CFG_ENTRY(cfg));
    snp_net_model u_snp_net_model (.CLK(clk), .RST(rst), .NET_LISTEN(listen), .NET_DIAL(dial),
        .NET_ACCEPT(accept), .NET_CLOSE(close), .NET_TX_VALID(tx_valid), .NET_TX_DATA(tx_data),
        .NET_PUSH(push), .NET_UP(net_up), .N_BYTES(n_bytes), .N_PUSH(n_push), .N_CLOSE(n_close),
        .LAST_BYTE(last_byte));
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc
    task automatic ser(input logic [7:0] b);
        @(posedge clk);
        ser_valid <= 1'b1;
        ser_data <= b;
        @(posedge clk);
        ser_valid <= 1'b0;
    endtask : ser
    task automatic pulse_req;
        @(posedge clk);
        net_req <= 1'b1;
        @(posedge clk);
        net_req <= 1'b0;
    endtask : pulse_req
    task automatic wait_ev(input int idx, input string name);
        int i;
        for (i = 0; i < 2000; i++) begin
            @(posedge clk);
            if (ev[idx] === 1'b1) break;
        end
        chk(name, 32'h0000_0001, {31'h0, ev[idx]});
    endtask : wait_ev
    task automatic t_reset;
        apb(1'b0, SNP_OFS_CTRL, 32'h0000_0000);
        chk("ctrl mode", {30'h0, SNP_RST_MODE}, rd & 32'h0000_0003);
        apb(1'b0, SNP_OFS_INACT, 32'h0000_0000);
        chk("inact", 32'h0000_0000, rd);
        apb(1'b0, 8'h3C, 32'h0000_0000);
        chk("unmapped err", 32'h0000_0001, {31'h0, err});
        chk("unmapped data", 32'h0000_0000, rd);
        wr(SNP_OFS_STATUS, 32'h0000_00FF);
        apb(1'b0, SNP_OFS_STATUS, 32'h0000_0000);
        chk("status state", 32'h0000_0001, rd & 32'h0000_0007);
        $display("test reset done");
    endtask : t_reset
    task automatic t_server;
        wr(SNP_OFS_PORTS, 32'h1388_0BB8);
        cyc(1);
        chk("local port", 32'h0000_0BB8, {16'h0, lport});
        chk("peer port", 32'h0000_1388, {16'h0, rport});
        pulse_req();
        wait_ev(1, "accept");
        cyc(2);
        chk("auth", 32'h0000_0001, {31'h0, auth});
        pulse_req();
        wait_ev(2, "refuse");
        $display("test server done");
    endtask : t_server
    task automatic t_pack;
        int i;
        b0 = n_bytes;
        p0 = n_push;
        ser(8'hA5);
        cyc(3);
        chk("imm bytes", {16'h0, b0 + 16'h1}, {16'h0, n_bytes});
        chk("imm push", {16'h0, p0 + 16'h1}, {16'h0, n_push});
        chk("imm data", 32'h0000_00A5, {24'h0, last_byte});
        wr(SNP_OFS_PSIZE, 32'h0000_0003);
        for (i = 0; i < 4; i++) ser(8'h30 + i[7:0]);
        cyc(3);
        chk("size push", {16'h0, p0 + 16'h2}, {16'h0, n_push});
        apb(1'b0, SNP_OFS_STATUS, 32'h0000_0000);
        chk("surplus", 32'h0000_0001, (rd >> 8) & 32'h0000_00FF);
        wr(SNP_OFS_PCHAR, 32'h0000_000D);
        ser(8'h77);
        ser(8'h0D);
        cyc(3);
        chk("delim push", {16'h0, p0 + 16'h3}, {16'h0, n_push});
        chk("delim bytes", {16'h0, b0 + 16'h6}, {16'h0, n_bytes});
        chk("delim last", 32'h0000_0077, {24'h0, last_byte});
        wr(SNP_OFS_PSIZE, 32'h0000_0000);
        wr(SNP_OFS_PCHAR, 32'h0000_0000);
        $display("test packing done");
    endtask : t_pack
    task automatic t_timer;
        c0 = n_close;
        wr(SNP_OFS_PTIME, 32'h0000_0002);
        p0 = n_push;
        ser(8'h11);
        cyc(60);
        chk("early push", {16'h0, p0}, {16'h0, n_push});
        cyc(60);
        chk("timer push", {16'h0, p0 + 16'h1}, {16'h0, n_push});
        cyc(450);
        chk("empty push", {16'h0, p0 + 16'h1}, {16'h0, n_push});
        chk("no idle close", {16'h0, c0}, {16'h0, n_close});
        wr(SNP_OFS_PTIME, 32'h0000_0000);
        wr(SNP_OFS_INACT, 32'h0000_0001);
        wait_ev(0, "idle close");
        cyc(3);
        chk("relisten", 32'h0000_0001, {31'h0, listen});
        wr(SNP_OFS_INACT, 32'h0000_0000);
        $display("test timers done");
    endtask : t_timer
    task automatic t_modes;
        wr(SNP_OFS_PEERIP, 32'h0A00_0002);
        wr(SNP_OFS_CTRL, {30'h0, SNP_MODE_CLIENT});
        cyc(3);
        chk("dial", 32'h0000_0001, {31'h0, dial});
        chk("peer ip", 32'h0A00_0002, peer_ip);
        wait_ev(4, "client auth");
        wr(SNP_OFS_CTRL, {30'h0, SNP_MODE_MIXED});
        cyc(3);
        chk("mixed listen", 32'h0000_0001, {31'h0, listen});
        ser(8'h22);
        cyc(2);
        apb(1'b0, SNP_OFS_STATUS, 32'h0000_0000);
        chk("client role", 32'h0000_0008, rd & 32'h0000_0008);
        wait_ev(4, "mixed auth");
        wr(SNP_OFS_CTRL, 32'h0000_0012);
        wait_ev(0, "mixed close");
        cyc(3);
        chk("mixed relisten", 32'h0000_0001, {31'h0, listen});
        wr(SNP_OFS_CTRL, 32'h0000_000B);
        cyc(3);
        chk("udp", 32'h0000_0003, {30'h0, udp, auth});
        chk("cfg entry", 32'h0000_0001, {31'h0, cfg});
        $display("test modes done");
    endtask : t_modes
    task automatic t_pw;
        int i;
        wr(SNP_OFS_PASSWD, 32'h4433_2211);
        wr(SNP_OFS_CTRL, 32'h0000_0005);
        cyc(3);
        pulse_req();
        wait_ev(1, "pw accept");
        cyc(2);
        apb(1'b0, SNP_OFS_STATUS, 32'h0000_0000);
        chk("pw wait", 32'h0000_0003, rd & 32'h0000_0017);
        for (i = 0; i < 4; i++) begin
            @(posedge clk);
            rx_valid <= 1'b1;
            rx_data <= 8'h11 * (i[7:0] + 8'h01);
        end
        @(posedge clk);
        rx_valid <= 1'b0;
        wait_ev(4, "pw auth");
        $display("test password done");
    endtask : t_pw
    task automatic test_done;
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : test_done
    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            n_errors++;
            test_done();
        end
    end
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_server();
        t_pack();
        t_timer();
        t_modes();
        t_pw();
        test_done();
    end
endmodule : tb
